/* logic/tds_pkg.sv */
// Package: register map, field positions, reset values and timing
// Assumes: 32-bit APB data, one aligned word per register
package tds_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00; // Enables and filter setup
  localparam logic [7:0] FILT1_OFS     = 8'h04; // Filter one frequency
  localparam logic [7:0] FILT2_OFS     = 8'h08; // Filter two frequency
  localparam logic [7:0] FILT3_OFS     = 8'h0C; // Filter three frequency
  localparam logic [7:0] FILT4_OFS     = 8'h10; // Filter four frequency
  localparam logic [7:0] FILT5_OFS     = 8'h14; // Filter five frequency
  localparam logic [7:0] OSC_LVL_OFS   = 8'h18; // Oscillation detect level
  localparam logic [7:0] PF_TIME_OFS   = 8'h1C; // Power fail time in ms
  localparam logic [7:0] UV_NORM_OFS   = 8'h20; // Normal bus alarm level
  localparam logic [7:0] STATUS_OFS    = 8'h24; // Live state, read only
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h28; // Sticky events, W1C
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h2C; // Interrupt enables
  localparam logic [7:0] ALARM_CLR_OFS = 8'h30; // Alarm reset, write only
  ////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTRL_VIB_EN    = 0; // Vibration tough drive enable
  localparam int CTRL_PWR_EN    = 1; // Power ride-through enable
  localparam int CTRL_SHAFT_REQ = 2; // Shaft resonance filter wanted
  localparam int CTRL_F4_EN     = 3; // Filter four enable
  localparam int CTRL_F5_EN     = 4; // Filter five enable
  localparam int CTRL_ROBUST    = 5; // Robust filter in use
  localparam int CTRL_W         = 6;
  // Status field positions
  localparam int ST_TOUGH  = 0;
  localparam int ST_CALARM = 1;
  localparam int ST_MALARM = 2;
  localparam int ST_UV     = 3;
  localparam int ST_BRAKE  = 4;
  localparam int ST_NVPEND = 5;
  localparam int ST_NVOK   = 6;
  localparam int ST_SHAFT  = 7;
  localparam int ST_F5     = 8;
  // Interrupt event positions
  localparam int EV_RETUNE = 0; // Filter one or two retuned
  localparam int EV_CALARM = 1; // Control supply drop alarm raised
  localparam int EV_MALARM = 2; // Main supply drop alarm raised
  localparam int EV_INTR   = 3; // Supply interruption started
  localparam int EV_NVDONE = 4; // Nonvolatile commit finished
  localparam int EV_W      = 5;
  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0]  CTRL_RST    = 6'h04; // Shaft filter on
  localparam logic [15:0] FILT_RST    = 16'h1194;
  localparam logic [15:0] OSC_LVL_RST = 16'h0100;
  localparam logic [15:0] PF_TIME_RST = 16'h00C8;
  localparam logic [15:0] UV_NORM_RST = 16'h00C8;
  ////////////////////////////////////////////////////////////////////////
  // Limits and timing
  localparam logic [15:0] MIN_RES_HZ   = 16'h0064; // 100 Hz floor
  localparam int          WIN_PCT      = 30;       // Retune window
  localparam logic [15:0] RIDE_UV_V    = 16'h009E; // 158 V DC
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int          NV_PERIOD_S   = 3600;    // One commit an hour
  localparam int          NV_PERIOD_MS  = NV_PERIOD_S * 1000;
endpackage

/* logic/tds_tick_div.sv */
// Millisecond enable divider for the supervisor timers
// Assumes: one free-running clock, asynchronous active-low reset
`timescale 1ns/1ns
module tds_tick_div #(
  parameter int DIV = 10000 // Clock cycles per tick
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // One-cycle enable
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1); // Terminal count

  logic [W-1:0] cnt_ff; // Cycle counter

  // Free-running count, wraps at terminal
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end
    else
    begin
      tick <= (cnt_ff == LAST);
      if (cnt_ff == LAST)
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + W'(1);
    end
  end
endmodule

/* logic/tds_supervisor.sv */
// Tough drive supervisor: filter retuning and supply ride-through
// Assumes: APB master on REF_CLK, detector and ADC words on REF_CLK,
// control supply sense is an asynchronous pin
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns

// Behaviour
// - Enable bits gate both tough drive functions
// - Retune only within 30 percent of filter
// - Overwrite the nearer of filters one, two
// - Commit to nonvolatile memory at most hourly
// - Never touch filters three, four, five
// - Ignore resonance at or below 100 Hz
// - Detection threshold from oscillation level register
// - Filter four disables shaft; robust masks five
// - Drop alarm time from power fail register
// - Ride-through switches bus alarm level to 158
// - Brake interlock held through ride-through
// - Control alarm once interruption exceeds time
// - Tough active asserts on interruption detect
// - Brake interlock drops when undervoltage raised
// - Bus below 158 V alarms during ride-through
// - Short dip above threshold gives no alarm
module tds_supervisor #(
  parameter int MS_CYC  = tds_pkg::MS_CYCLES,    // Cycles per ms
  parameter int HOUR_MS = tds_pkg::NV_PERIOD_MS  // Commit spacing, ms
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Resonance detector
  input  wire logic        RES_VALID,
  input  wire logic [15:0] RES_FREQ,
  input  wire logic [15:0] RES_LEVEL,
  // Supply sensing
  input  wire logic        CTRL_SUPPLY_LOW,
  input  wire logic [15:0] BUS_VOLT,
  // Nonvolatile write port
  output logic             NV_WR_REQ,
  output logic      [31:0] NV_WR_DATA,
  input  wire logic        NV_WR_ACK,
  // Filter datapath settings
  output logic      [15:0] FILT1_FREQ,
  output logic      [15:0] FILT2_FREQ,
  output logic             SHAFT_FILT_EN,
  output logic             FILT4_EN,
  output logic             FILT5_EN,
  // Drive outputs
  output logic             TOUGH_ACTIVE_OUT,
  output logic             BRAKE_INTERLOCK_OUT,
  output logic             UNDERVOLTAGE_ALARM,
  output logic             CONTROL_SUPPLY_DROP_ALARM,
  output logic             MAIN_SUPPLY_DROP_ALARM,
  output logic             IRQ
);
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  typedef enum logic [1:0] {NV_IDLE, NV_WRITE, NV_WAIT} tds_nv_t;

  // Distance between two frequencies
  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Distance within retune window
  function automatic logic in_window(input logic [15:0] d,
                                     input logic [15:0] f);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(d) * 24'd100;
    rhs = 24'(f) * 24'(tds_pkg::WIN_PCT);
    in_window = (lhs <= rhs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [tds_pkg::CTRL_W-1:0] ctrl_ff;    // Control bits
  logic [15:0]       f3_ff;              // Filter three frequency
  logic [15:0]       f4_ff;              // Filter four frequency
  logic [15:0]       f5_ff;              // Filter five frequency
  logic [15:0]       osc_lvl_ff;         // Detection level
  logic [15:0]       pf_time_ff;         // Power fail time, ms
  logic [15:0]       uv_norm_ff;         // Normal bus alarm level
  logic [tds_pkg::EV_W-1:0] irq_stat_ff; // Sticky events
  logic [tds_pkg::EV_W-1:0] irq_mask_ff; // Event enables
  logic              sup_meta_ff;        // Supply sense, stage one
  logic              sup_sync_ff;        // Supply sense, stage two
  logic              intr_ff;            // Interruption seen last cycle
  logic [15:0]       intr_ms_ff;         // Interruption length, ms
  logic              nv_pend_ff;         // Retuned values not committed
  logic [31:0]       hour_ms_ff;         // Ms since last commit
  tds_nv_t           nv_state_ff;        // Commit sequencer

  logic              ms_tick;            // One-millisecond enable
  logic              wr_en;              // APB write takes effect
  logic              rd_setup;           // APB setup cycle of a read
  logic              hit;                // Address is mapped
  logic [31:0]       rd_mux;             // Read data selection
  logic [15:0]       d1;                 // Distance to filter one
  logic [15:0]       d2;                 // Distance to filter two
  logic              res_ok;             // Detection accepted
  logic              pick1;              // Filter one is nearer
  logic              retune1;            // Overwrite filter one
  logic              retune2;            // Overwrite filter two
  logic              nxt_calarm;         // Control alarm next value
  logic              nxt_malarm;         // Main alarm next value
  logic              alarm_clr;          // Software alarm reset
  logic [15:0]       uv_level;           // Bus alarm level in use
  logic [tds_pkg::EV_W-1:0] ev;          // Event pulses

  ////////////////////////////////////////////////////////////////////////
  // Millisecond base for all timers
  tds_tick_div #(
    .DIV (MS_CYC)
  ) u_ms (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .tick  (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  assign wr_en     = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_setup  = PSEL & ~PENABLE & ~PWRITE;
  assign alarm_clr = wr_en & (PADDR == tds_pkg::ALARM_CLR_OFS) & PWDATA[0];

  // Read data and address hit
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    case (PADDR)
      tds_pkg::CTRL_OFS:      rd_mux = 32'(ctrl_ff);
      tds_pkg::FILT1_OFS:     rd_mux = 32'(FILT1_FREQ);
      tds_pkg::FILT2_OFS:     rd_mux = 32'(FILT2_FREQ);
      tds_pkg::FILT3_OFS:     rd_mux = 32'(f3_ff);
      tds_pkg::FILT4_OFS:     rd_mux = 32'(f4_ff);
      tds_pkg::FILT5_OFS:     rd_mux = 32'(f5_ff);
      tds_pkg::OSC_LVL_OFS:   rd_mux = 32'(osc_lvl_ff);
      tds_pkg::PF_TIME_OFS:   rd_mux = 32'(pf_time_ff);
      tds_pkg::UV_NORM_OFS:   rd_mux = 32'(uv_norm_ff);
      tds_pkg::STATUS_OFS:
      begin
        rd_mux[tds_pkg::ST_TOUGH]  = TOUGH_ACTIVE_OUT;
        rd_mux[tds_pkg::ST_CALARM] = CONTROL_SUPPLY_DROP_ALARM;
        rd_mux[tds_pkg::ST_MALARM] = MAIN_SUPPLY_DROP_ALARM;
        rd_mux[tds_pkg::ST_UV]     = UNDERVOLTAGE_ALARM;
        rd_mux[tds_pkg::ST_BRAKE]  = BRAKE_INTERLOCK_OUT;
        rd_mux[tds_pkg::ST_NVPEND] = nv_pend_ff;
        rd_mux[tds_pkg::ST_NVOK]   = (nv_state_ff == NV_IDLE);
        rd_mux[tds_pkg::ST_SHAFT]  = SHAFT_FILT_EN;
        rd_mux[tds_pkg::ST_F5]     = FILT5_EN;
      end
      tds_pkg::IRQ_STAT_OFS:  rd_mux = 32'(irq_stat_ff);
      tds_pkg::IRQ_MASK_OFS:  rd_mux = 32'(irq_mask_ff);
      tds_pkg::ALARM_CLR_OFS: rd_mux = 32'h0000_0000;
      default:                hit    = 1'b0;
    endcase
  end

  // Answer latched at setup, shown in access
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      PREADY  <= 1'b0;
    end
    else
    begin
      PREADY <= 1'b1;
      if (PSEL & ~PENABLE)
      begin
        PRDATA  <= rd_setup ? rd_mux : 32'h0000_0000;
        PSLVERR <= ~hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain setting registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_ff     <= tds_pkg::CTRL_RST;
      f3_ff       <= tds_pkg::FILT_RST;
      f4_ff       <= tds_pkg::FILT_RST;
      f5_ff       <= tds_pkg::FILT_RST;
      osc_lvl_ff  <= tds_pkg::OSC_LVL_RST;
      pf_time_ff  <= tds_pkg::PF_TIME_RST;
      uv_norm_ff  <= tds_pkg::UV_NORM_RST;
      irq_mask_ff <= '0;
    end
    else if (wr_en)
    begin
      case (PADDR)
        tds_pkg::CTRL_OFS:     ctrl_ff     <= PWDATA[tds_pkg::CTRL_W-1:0];
        tds_pkg::FILT3_OFS:    f3_ff       <= PWDATA[15:0];
        tds_pkg::FILT4_OFS:    f4_ff       <= PWDATA[15:0];
        tds_pkg::FILT5_OFS:    f5_ff       <= PWDATA[15:0];
        tds_pkg::OSC_LVL_OFS:  osc_lvl_ff  <= PWDATA[15:0];
        tds_pkg::PF_TIME_OFS:  pf_time_ff  <= PWDATA[15:0];
        tds_pkg::UV_NORM_OFS:  uv_norm_ff  <= PWDATA[15:0];
        tds_pkg::IRQ_MASK_OFS: irq_mask_ff <= PWDATA[tds_pkg::EV_W-1:0];
        default:               ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Resonance check, nearest filter
  assign d1     = absdiff(RES_FREQ, FILT1_FREQ);
  assign d2     = absdiff(RES_FREQ, FILT2_FREQ);
  assign pick1  = (d1 <= d2);
  assign res_ok = RES_VALID & ctrl_ff[tds_pkg::CTRL_VIB_EN]
                & (RES_FREQ > tds_pkg::MIN_RES_HZ)
                & (RES_LEVEL >= osc_lvl_ff);
  assign retune1 = res_ok & pick1 & in_window(d1, FILT1_FREQ);
  assign retune2 = res_ok & ~pick1 & in_window(d2, FILT2_FREQ);

  // Working filters; retune beats a write
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FILT1_FREQ <= tds_pkg::FILT_RST;
      FILT2_FREQ <= tds_pkg::FILT_RST;
    end
    else
    begin
      if (retune1)
        FILT1_FREQ <= RES_FREQ;
      else if (wr_en && PADDR == tds_pkg::FILT1_OFS)
        FILT1_FREQ <= PWDATA[15:0];
      if (retune2)
        FILT2_FREQ <= RES_FREQ;
      else if (wr_en && PADDR == tds_pkg::FILT2_OFS)
        FILT2_FREQ <= PWDATA[15:0];
    end
  end

  // Datapath enables; filters three to five never retuned
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SHAFT_FILT_EN <= 1'b0;
      FILT4_EN      <= 1'b0;
      FILT5_EN      <= 1'b0;
    end
    else
    begin
      FILT4_EN      <= ctrl_ff[tds_pkg::CTRL_F4_EN];
      SHAFT_FILT_EN <= ctrl_ff[tds_pkg::CTRL_SHAFT_REQ]
                     & ~ctrl_ff[tds_pkg::CTRL_F4_EN];
      FILT5_EN      <= ctrl_ff[tds_pkg::CTRL_F5_EN]
                     & ~ctrl_ff[tds_pkg::CTRL_ROBUST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Nonvolatile commit, at most hourly
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      nv_state_ff <= NV_IDLE;
      nv_pend_ff  <= 1'b0;
      hour_ms_ff  <= 32'h0000_0000;
      NV_WR_REQ   <= 1'b0;
      NV_WR_DATA  <= 32'h0000_0000;
    end
    else
    begin
      // Retune beats a same-cycle commit
      if (retune1 | retune2)
        nv_pend_ff <= 1'b1;
      else if (nv_state_ff == NV_WRITE && NV_WR_ACK)
        nv_pend_ff <= 1'b0;
      case (nv_state_ff)
        NV_IDLE:
        begin
          if (nv_pend_ff)
          begin
            NV_WR_REQ   <= 1'b1;
            NV_WR_DATA  <= {FILT2_FREQ, FILT1_FREQ};
            nv_state_ff <= NV_WRITE;
          end
        end
        NV_WRITE:
        begin
          if (NV_WR_ACK)
          begin
            NV_WR_REQ   <= 1'b0;
            hour_ms_ff  <= 32'h0000_0000;
            nv_state_ff <= NV_WAIT;
          end
        end
        NV_WAIT:
        begin
          if (ms_tick)
          begin
            if (hour_ms_ff >= 32'(HOUR_MS - 1))
              nv_state_ff <= NV_IDLE;
            else
              hour_ms_ff <= hour_ms_ff + 32'h0000_0001;
          end
        end
        default: nv_state_ff <= NV_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply sense synchroniser, interruption timer
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sup_meta_ff <= 1'b0;
      sup_sync_ff <= 1'b0;
      intr_ff     <= 1'b0;
      intr_ms_ff  <= 16'h0000;
    end
    else
    begin
      sup_meta_ff <= CTRL_SUPPLY_LOW;
      sup_sync_ff <= sup_meta_ff;
      intr_ff     <= sup_sync_ff;
      if (!sup_sync_ff)
        intr_ms_ff <= 16'h0000;
      else if (ms_tick && intr_ms_ff != 16'hFFFF)
        intr_ms_ff <= intr_ms_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm decisions
  assign uv_level = ctrl_ff[tds_pkg::CTRL_PWR_EN]
                  ? tds_pkg::RIDE_UV_V : uv_norm_ff;

  always_comb
  begin
    // Without ride-through any interruption alarms at once
    nxt_calarm = CONTROL_SUPPLY_DROP_ALARM & ~alarm_clr;
    if (sup_sync_ff && (!ctrl_ff[tds_pkg::CTRL_PWR_EN]
                        || intr_ms_ff > pf_time_ff))
      nxt_calarm = 1'b1;
    // Bus level checked even for short dips
    nxt_malarm = MAIN_SUPPLY_DROP_ALARM & ~alarm_clr;
    if (BUS_VOLT < uv_level)
      nxt_malarm = 1'b1;
  end

  // Latched alarms and drive outputs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CONTROL_SUPPLY_DROP_ALARM <= 1'b0;
      MAIN_SUPPLY_DROP_ALARM    <= 1'b0;
      UNDERVOLTAGE_ALARM        <= 1'b0;
      BRAKE_INTERLOCK_OUT       <= 1'b0;
      TOUGH_ACTIVE_OUT          <= 1'b0;
    end
    else
    begin
      CONTROL_SUPPLY_DROP_ALARM <= nxt_calarm;
      MAIN_SUPPLY_DROP_ALARM    <= nxt_malarm;
      UNDERVOLTAGE_ALARM        <= nxt_calarm | nxt_malarm;
      BRAKE_INTERLOCK_OUT       <= ~(nxt_calarm | nxt_malarm);
      TOUGH_ACTIVE_OUT          <= sup_sync_ff
                                 & ctrl_ff[tds_pkg::CTRL_PWR_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events, status and output
  always_comb
  begin
    ev = '0;
    ev[tds_pkg::EV_RETUNE] = retune1 | retune2;
    ev[tds_pkg::EV_CALARM] = nxt_calarm & ~CONTROL_SUPPLY_DROP_ALARM;
    ev[tds_pkg::EV_MALARM] = nxt_malarm & ~MAIN_SUPPLY_DROP_ALARM;
    ev[tds_pkg::EV_INTR]   = sup_sync_ff & ~intr_ff;
    ev[tds_pkg::EV_NVDONE] = (nv_state_ff == NV_WRITE) & NV_WR_ACK;
  end

  // Sticky bits; set beats clear
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_stat_ff <= '0;
      IRQ         <= 1'b0;
    end
    else
    begin
      if (wr_en && PADDR == tds_pkg::IRQ_STAT_OFS)
        irq_stat_ff <= (irq_stat_ff & ~PWDATA[tds_pkg::EV_W-1:0]) | ev;
      else
        irq_stat_ff <= irq_stat_ff | ev;
      IRQ <= |(irq_stat_ff & irq_mask_ff);
    end
  end
endmodule

/* verification/tds_sup_props.sv */
// Checker: port assertions for the supervisor
// Assumes: bound into tds_supervisor, one clock domain on REF_CLK
`timescale 1ns/1ns
module tds_sup_props #(
  parameter int MS_CYC  = 10, // Cycles per ms tick
  parameter int HOUR_MS = 5   // Commit spacing in ms
) (
  // Clock, reset and bus
  input wire logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE,
  input wire logic [7:0]  PADDR,
  // Stimulus and observed outputs
  input wire logic        RES_VALID, CTRL_SUPPLY_LOW, NV_WR_REQ, NV_WR_ACK,
  input wire logic [15:0] BUS_VOLT, FILT1_FREQ, FILT2_FREQ,
  input wire logic [31:0] NV_WR_DATA,
  input wire logic        SHAFT_FILT_EN, FILT4_EN, TOUGH_ACTIVE_OUT,
  input wire logic        BRAKE_INTERLOCK_OUT, UNDERVOLTAGE_ALARM,
  input wire logic        MAIN_SUPPLY_DROP_ALARM, CONTROL_SUPPLY_DROP_ALARM
);
  localparam int GAP = (HOUR_MS - 1) * MS_CYC; // Shortest legal spacing
  logic [31:0] gap_ff; // Cycles since last accepted commit
  logic        wr;     // Write in access phase
  assign wr = PSEL && PENABLE && PWRITE;
  ////////////////////////////////////////////////////////////////////////
  // Spacing counter, saturates at the legal gap
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      gap_ff <= 32'(GAP);
    else if (NV_WR_REQ && NV_WR_ACK)
      gap_ff <= '0;
    else if (gap_ff < 32'(GAP))
      gap_ff <= gap_ff + 32'h1;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////
  a_brake_follow: assert property ($past(RST_N) |->
    BRAKE_INTERLOCK_OUT != UNDERVOLTAGE_ALARM) else $error("brake vs alarm");
  a_low_bus: assert property (BUS_VOLT < tds_pkg::RIDE_UV_V |=>
    MAIN_SUPPLY_DROP_ALARM) else $error("low bus without alarm");
  a_alarm_hold: assert property (UNDERVOLTAGE_ALARM && !(wr &&
    PADDR == tds_pkg::ALARM_CLR_OFS) |=> UNDERVOLTAGE_ALARM)
    else $error("alarm dropped on its own");
  a_tough_rise: assert property ($rose(CTRL_SUPPLY_LOW) |-> ##3
    (TOUGH_ACTIVE_OUT || CONTROL_SUPPLY_DROP_ALARM))
    else $error("dip not flagged");
  a_nv_hold: assert property (NV_WR_REQ && !NV_WR_ACK |=>
    NV_WR_REQ && $stable(NV_WR_DATA)) else $error("commit request lost");
  a_nv_drop: assert property (NV_WR_REQ && NV_WR_ACK |=> !NV_WR_REQ)
    else $error("request held after ack");
  a_nv_space: assert property ($rose(NV_WR_REQ) |-> gap_ff >= GAP)
    else $error("commits too close");
  a_filt_cause: assert property ($changed(FILT1_FREQ) ||
    $changed(FILT2_FREQ) |-> $past(RES_VALID) || $past(wr))
    else $error("filter moved without cause");
  a_shaft_excl: assert property (!(SHAFT_FILT_EN && FILT4_EN))
    else $error("shaft filter with filter four");
endmodule
bind tds_supervisor tds_sup_props #(
  .MS_CYC(MS_CYC), .HOUR_MS(HOUR_MS)
) tds_sup_props_i (.*);

/* verification/testbench.sv */
// Testbench: self-checking run of the tough drive supervisor
// Assumes: short ms tick and commit period
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] NOM = 16'h012C; // Healthy bus, 300 V
  // Design ports
  logic        REF_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, RES_VALID = 1'b0, CTRL_SUPPLY_LOW = 1'b0;
  logic        NV_WR_ACK = 1'b0, PREADY, PSLVERR, NV_WR_REQ, IRQ;
  logic        SHAFT_FILT_EN, FILT4_EN, FILT5_EN, TOUGH_ACTIVE_OUT;
  logic        BRAKE_INTERLOCK_OUT, UNDERVOLTAGE_ALARM;
  logic        CONTROL_SUPPLY_DROP_ALARM, MAIN_SUPPLY_DROP_ALARM;
  logic [7:0]  PADDR = 8'h00;
  logic [15:0] RES_FREQ = 16'h0, RES_LEVEL = 16'h0, BUS_VOLT = NOM;
  logic [15:0] FILT1_FREQ, FILT2_FREQ;
  logic [31:0] PWDATA = 32'h0, PRDATA, NV_WR_DATA, rd_q;
  // Bench state
  int          err_count = 0, cmp_count = 0, cyc = 0, i;
  int          seed = 32'h2CF5B121;
  logic [15:0] f1_exp, f2_exp; // Expected working filters
  logic        vib_on, slv_q;  // Vibration enable, last error flag
  logic [5:0]  ctl;            // Control word under test
  tds_supervisor #(.MS_CYC(10), .HOUR_MS(5)) tds_supervisor_i (.*);
  always #50 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer, entered after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    rd_q = PRDATA;
    slv_q = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  // Filter to retune: 1, 2 or 0
  function automatic logic [1:0] pick(input logic [15:0] f, l);
    int d1, d2;
    d1 = (f > f1_exp) ? f - f1_exp : f1_exp - f;
    d2 = (f > f2_exp) ? f - f2_exp : f2_exp - f;
    if (!vib_on || f <= tds_pkg::MIN_RES_HZ || l < tds_pkg::OSC_LVL_RST)
      return 2'h0;
    if (d1 <= d2)
      return (100 * d1 <= tds_pkg::WIN_PCT * f1_exp) ? 2'h1 : 2'h0;
    return (100 * d2 <= tds_pkg::WIN_PCT * f2_exp) ? 2'h2 : 2'h0;
  endfunction
  // Expected main alarm
  function automatic logic main_exp(input logic [15:0] v, input logic r);
    return v < (r ? tds_pkg::RIDE_UV_V : tds_pkg::UV_NORM_RST);
  endfunction
  // Detector pulse, then filter check
  task automatic det(input logic [15:0] f, input logic [15:0] l);
    logic [1:0] p;
    p = pick(f, l);
    RES_FREQ <= f;
    RES_LEVEL <= l;
    RES_VALID <= 1'b1;
    @(posedge REF_CLK);
    RES_VALID <= 1'b0;
    f1_exp = (p == 2'h1) ? f : f1_exp;
    f2_exp = (p == 2'h2) ? f : f2_exp;
    @(posedge REF_CLK);
    chk(FILT1_FREQ, f1_exp);
    chk(FILT2_FREQ, f2_exp);
  endtask
  // Supply pin and bus level, then wait
  task automatic sup(input logic lo, input logic [15:0] v, input int n);
    CTRL_SUPPLY_LOW <= lo;
    BUS_VOLT <= v;
    repeat (n) @(posedge REF_CLK);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Random commit acknowledge and hang guard
  always @(posedge REF_CLK)
  begin
    cyc++;
    NV_WR_ACK <= NV_WR_REQ && ($random(seed) % 2 != 0);
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    for (i = 0; i < 9; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd_q, (i == 0) ? 32'h04 : (i < 6) ? 32'h1194 :
                (i == 6) ? 32'h0100 : 32'h00C8);
    end
    apb(1'b0, 8'h34, 32'h0);
    chk(32'(slv_q), 32'h1);
    chk(rd_q, 32'h0);
    $display("Test done: reset values");
    apb(1'b1, tds_pkg::CTRL_OFS, 32'h07);
    apb(1'b1, tds_pkg::FILT1_OFS, 32'h03E8);
    apb(1'b1, tds_pkg::FILT2_OFS, 32'h0BB8);
    apb(1'b1, tds_pkg::PF_TIME_OFS, 32'h03);
    apb(1'b1, tds_pkg::IRQ_MASK_OFS, 32'h01);
    apb(1'b1, tds_pkg::IRQ_STAT_OFS, 32'h1F);
    vib_on = 1'b1;
    f1_exp = 16'h03E8;
    f2_exp = 16'h0BB8;
    det(16'h0515, 16'h0200);
    det(16'h0514, 16'h0200);
    while (NV_WR_REQ !== 1'b1) @(posedge REF_CLK);
    chk(NV_WR_DATA, {f2_exp, f1_exp});
    chk(IRQ, 1'b1);
    apb(1'b1, tds_pkg::IRQ_MASK_OFS, 32'h00);
    apb(1'b1, tds_pkg::IRQ_STAT_OFS, 32'h01);
    det(16'h0578, 16'h0200);
    apb(1'b0, tds_pkg::IRQ_STAT_OFS, 32'h0);
    chk({IRQ, rd_q[0]}, 2'h1);
    $display("Test done: window, commit, interrupt");
    apb(1'b1, tds_pkg::FILT1_OFS, 32'h0078);
    f1_exp = 16'h0078;
    det(16'h0064, 16'h0200);
    det(16'h0065, 16'h0200);
    det(16'h006E, 16'h00FF);
    apb(1'b1, tds_pkg::CTRL_OFS, 32'h06);
    vib_on = 1'b0;
    det(16'h006E, 16'h0200);
    apb(1'b1, tds_pkg::CTRL_OFS, 32'h07);
    vib_on = 1'b1;
    for (i = 0; i < 40; i++)
      det(16'h0040 + 16'($random(seed) & 32'h0FFF),
          16'h00C0 + 16'($random(seed) & 32'h007F));
    apb(1'b0, tds_pkg::FILT3_OFS, 32'h0);
    chk(rd_q, 32'h1194);
    $display("Test done: retune corners and random");
    sup(1'b1, 16'h00B4, 8);
    chk({TOUGH_ACTIVE_OUT, BRAKE_INTERLOCK_OUT}, 2'h3);
    sup(1'b0, NOM, 4);
    chk(UNDERVOLTAGE_ALARM, main_exp(16'h00B4, 1'b1));
    sup(1'b1, NOM, 25);
    chk(CONTROL_SUPPLY_DROP_ALARM, 1'b0);
    sup(1'b1, NOM, 25);
    chk({CONTROL_SUPPLY_DROP_ALARM, BRAKE_INTERLOCK_OUT}, 2'h2);
    sup(1'b0, NOM, 4);
    apb(1'b1, tds_pkg::ALARM_CLR_OFS, 32'h01);
    chk({UNDERVOLTAGE_ALARM, BRAKE_INTERLOCK_OUT}, 2'h1);
    sup(1'b1, 16'h0096, 4);
    chk(MAIN_SUPPLY_DROP_ALARM, main_exp(16'h0096, 1'b1));
    sup(1'b0, NOM, 4);
    apb(1'b1, tds_pkg::CTRL_OFS, 32'h05);
    apb(1'b1, tds_pkg::ALARM_CLR_OFS, 32'h01);
    sup(1'b1, 16'h00B4, 6);
    chk({TOUGH_ACTIVE_OUT, CONTROL_SUPPLY_DROP_ALARM}, 2'h1);
    chk(MAIN_SUPPLY_DROP_ALARM, main_exp(16'h00B4, 1'b0));
    sup(1'b0, NOM, 0);
    $display("Test done: supply ride-through");
    for (i = 0; i < 8; i++)
    begin
      ctl = (i == 0) ? 6'h0C : (i == 1) ? 6'h34 : 6'($random(seed));
      apb(1'b1, tds_pkg::CTRL_OFS, {26'h0, ctl});
      @(posedge REF_CLK);
      chk({SHAFT_FILT_EN, FILT4_EN, FILT5_EN},
          {ctl[2] & ~ctl[3], ctl[3], ctl[4] & ~ctl[5]});
    end
    $display("Test done: filter enables");
    stop_test();
  end
endmodule
